/* File: rtl/irq_entry_return_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.svh"
module irq_entry_return_sequencer #(
   parameter int NUM_SRC = 8,
   parameter int PC_W = 12,
   parameter logic [NUM_SRC-1:0] LEVEL_SRC = '0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0] src_level,
   input wire logic retire_valid,
   input wire irq_pkg::core_retire_t retire,
   input wire logic sleeping,
   output var irq_pkg::sram_req_t sram_req,
   input wire logic [7:0] sram_rdata,
   output logic core_hold,
   output logic pc_load,
   output logic [PC_W-1:0] pc_value,
   output logic handler_entered,
   output logic global_enable
);
   import irq_pkg::*;

   // software visible state
   logic [NUM_SRC-1:0] enable;
   logic [NUM_SRC-1:0] flag;
   logic [7:0] status_word;
   logic [15:0] stack_ptr;

   // sequencer state
   seq_state_t state;
   seq_state_t next_state;
   logic skip_one;
   logic [3:0] wake_cnt;
   logic [3:0] jump_cnt;
   logic [$clog2(NUM_SRC+1)-1:0] sel_idx;
   logic [15:0] saved_pc;
   logic [7:0] pop_hi;

   // bus data phase bookkeeping
   logic wr_pend;
   logic rd_pend;
   logic [7:0] bus_addr;

   // stack port handshake
   logic st_start;
   logic st_wr;
   logic [15:0] st_addr;
   logic [7:0] st_wdata;
   logic st_done;

   // derived request terms
   logic [NUM_SRC-1:0] pending;
   logic any_pending;
   logic [$clog2(NUM_SRC+1)-1:0] win_idx;
   logic take;
   logic boundary_ok;
   logic entry_done;
   logic return_done;
   logic bus_accept;
   logic sw_wr_flag;
   logic sw_wr_status;
   logic sw_wr_enable;
   logic sw_wr_stack;

   assign global_enable = status_word[`GIE_BIT];

   // pending terms: flag sources latch, level sources follow the condition
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         if (LEVEL_SRC[gi]) begin : g_level
            assign pending[gi] = enable[gi] & src_level[gi];
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) begin
                  flag[gi] <= 1'b0;
               end else begin
                  flag[gi] <= src_level[gi];
               end
            end
         end else begin : g_flag
            assign pending[gi] = enable[gi] & flag[gi];
            // a new event beats any clear in the same cycle
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) begin
                  flag[gi] <= 1'b0;
               end else if (src_event[gi]) begin
                  flag[gi] <= 1'b1;
               end else if (entry_done && (sel_idx == gi)) begin
                  flag[gi] <= 1'b0;
               end else if (sw_wr_flag && hwdata[gi]) begin
                  flag[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // lowest index wins; index zero is ext_request_zero
   always_comb begin
      any_pending = 1'b0;
      win_idx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            any_pending = 1'b1;
            win_idx = ($clog2(NUM_SRC+1))'(i);
         end
      end
   end

   // an interrupt is only taken at a completed instruction boundary or from sleep;
   // the disable and return instructions block a same-cycle take
   assign boundary_ok = (retire_valid && !skip_one && (retire.op != OP_DISABLE) &&
                         (retire.op != OP_RETURN)) || (sleeping && !retire_valid);
   assign take = (state == ST_RUN) && global_enable && any_pending && boundary_ok;
   assign entry_done = (state == ST_PUSH_HI) && st_done;
   assign return_done = (state == ST_POP_LO) && st_done;

   // sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET_VEC: next_state = ST_RUN;
         ST_RUN: begin
            if (take) begin
               next_state = sleeping ? ST_WAKE : ST_PUSH_LO;
            end else if (retire_valid && (retire.op == OP_RETURN)) begin
               next_state = ST_POP_HI;
            end
         end
         ST_WAKE: begin
            if (wake_cnt == 4'h0) begin
               next_state = ST_PUSH_LO;
            end
         end
         ST_PUSH_LO: begin
            if (st_done) begin
               next_state = ST_PUSH_HI;
            end
         end
         ST_PUSH_HI: begin
            if (st_done) begin
               next_state = ST_RUN;
            end
         end
         ST_POP_HI: begin
            if (st_done) begin
               next_state = ST_POP_LO;
            end
         end
         ST_POP_LO: begin
            if (st_done) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   // stack access requests; only the program counter ever goes on the stack
   always_comb begin
      st_start = 1'b0;
      st_wr = 1'b0;
      st_addr = stack_ptr;
      st_wdata = saved_pc[7:0];
      if ((next_state == ST_PUSH_LO) && (state != ST_PUSH_LO)) begin
         st_start = 1'b1;
         st_wr = 1'b1;
         st_addr = stack_ptr;
         st_wdata = (state == ST_WAKE) ? saved_pc[7:0] : retire.next_pc[7:0];
      end else if ((next_state == ST_PUSH_HI) && (state != ST_PUSH_HI)) begin
         st_start = 1'b1;
         st_wr = 1'b1;
         st_addr = stack_ptr - 16'h0001;
         st_wdata = saved_pc[15:8];
      end else if ((next_state == ST_POP_HI) && (state != ST_POP_HI)) begin
         st_start = 1'b1;
         st_addr = stack_ptr + 16'h0001;
      end else if ((next_state == ST_POP_LO) && (state != ST_POP_LO)) begin
         st_start = 1'b1;
         st_addr = stack_ptr + 16'(`SP_STEP);
      end
   end

   stack_port #(
      .ACC_CYCLES(`SRAM_ACCESS_CYCLES)
   ) u_stack_port (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(st_start),
      .wr(st_wr),
      .addr(st_addr),
      .wdata(st_wdata),
      .sram_req(sram_req),
      .done(st_done)
   );

   // state register; the core clock is used as is, no divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_RESET_VEC;
      end else begin
         state <= next_state;
      end
   end

   // captured context of the current entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_idx <= '0;
         saved_pc <= 16'h0000;
         wake_cnt <= 4'h0;
      end else if (take) begin
         sel_idx <= win_idx;
         saved_pc <= retire.next_pc;
         wake_cnt <= 4'(`WAKE_EXTRA_CYCLES - 1);
      end else if ((state == ST_WAKE) && (wake_cnt != 4'h0)) begin
         wake_cnt <= wake_cnt - 4'h1;
      end
   end

   // high byte of the popped return address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pop_hi <= 8'h00;
      end else if ((state == ST_POP_HI) && st_done) begin
         pop_hi <= sram_rdata;
      end
   end

   // vector and resume loads toward the fetch unit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_load <= 1'b0;
         pc_value <= '0;
      end else if (state == ST_RESET_VEC) begin
         pc_load <= 1'b1;
         pc_value <= PC_W'(`VEC_BASE);
      end else if (entry_done) begin
         pc_load <= 1'b1;
         pc_value <= PC_W'(`VEC_BASE + (int'(sel_idx) + 1) * `VEC_SLOT);
      end else if (return_done) begin
         pc_load <= 1'b1;
         pc_value <= PC_W'({pop_hi, sram_rdata});
      end else begin
         pc_load <= 1'b0;
      end
   end

   // core stall while the sequencer owns the stack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_hold <= 1'b1;
      end else begin
         core_hold <= (next_state != ST_RUN);
      end
   end

   // count off the vector jump so the handler_entered output marks the handler reached
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         jump_cnt <= 4'h0;
         handler_entered <= 1'b0;
      end else if (entry_done) begin
         jump_cnt <= 4'(`JUMP_CYCLES);
         handler_entered <= 1'b0;
      end else if (jump_cnt != 4'h0) begin
         jump_cnt <= jump_cnt - 4'h1;
         handler_entered <= (jump_cnt == 4'h1);
      end else begin
         handler_entered <= 1'b0;
      end
   end

   // one-instruction guard after unmask and after return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         skip_one <= 1'b0;
      end else if (return_done) begin
         skip_one <= 1'b1;
      end else if (retire_valid && (state == ST_RUN)) begin
         skip_one <= (retire.op == OP_UNMASK);
      end
   end

   // stack pointer; hardware updates beat a software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_ptr <= `SP_RESET;
      end else if (entry_done) begin
         stack_ptr <= stack_ptr - 16'(`SP_STEP);
      end else if (return_done) begin
         stack_ptr <= stack_ptr + 16'(`SP_STEP);
      end else if (sw_wr_stack) begin
         stack_ptr <= hwdata[15:0];
      end
   end

   // status word; global enable has several masters, in this order
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_word <= `STATUS_RESET;
      end else if (return_done) begin
         status_word[`GIE_BIT] <= 1'b1;
      end else if (take) begin
         status_word[`GIE_BIT] <= 1'b0;
      end else if (retire_valid && (retire.op == OP_DISABLE)) begin
         status_word[`GIE_BIT] <= 1'b0;
      end else if (retire_valid && (retire.op == OP_UNMASK)) begin
         status_word[`GIE_BIT] <= 1'b1;
      end else if (sw_wr_status) begin
         status_word <= hwdata[7:0];
      end
   end

   // per-source enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable <= '0;
      end else if (sw_wr_enable) begin
         enable <= hwdata[NUM_SRC-1:0];
      end
   end

   // bus address phase; reads take one wait state so a write just before is seen
   assign bus_accept = hsel && hready && htrans[1];
   assign sw_wr_enable = wr_pend && (bus_addr == `OFS_ENABLE);
   assign sw_wr_flag = wr_pend && (bus_addr == `OFS_FLAG);
   assign sw_wr_status = wr_pend && (bus_addr == `OFS_STATUS);
   assign sw_wr_stack = wr_pend && (bus_addr == `OFS_STACK);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         bus_addr <= 8'h00;
      end else begin
         wr_pend <= bus_accept && hwrite;
         rd_pend <= bus_accept && !hwrite;
         if (bus_accept) begin
            bus_addr <= {haddr[7:2], 2'b00};
         end
      end
   end

   // ready and response; always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= !(bus_accept && !hwrite);
         hresp <= 1'b0;
      end
   end

   // read mux; unmapped offsets read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend) begin
         unique case (bus_addr)
            `OFS_ENABLE: hrdata <= 32'(enable);
            `OFS_FLAG: hrdata <= 32'(flag);
            `OFS_STATUS: hrdata <= {24'h000000, status_word};
            `OFS_STACK: hrdata <= {16'h0000, stack_ptr};
            `OFS_STATE: hrdata <= {16'h0000, 7'h00, skip_one, 5'h00, state};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: rtl/stack_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.svh"
module stack_port #(
   parameter int ACC_CYCLES = `SRAM_ACCESS_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output var irq_pkg::sram_req_t sram_req,
   output logic done
);
   import irq_pkg::*;

   logic busy;
   logic [3:0] cnt;

   // done is combinational so back to back accesses chain with no gap
   assign done = busy && (cnt == 4'(ACC_CYCLES - 1));

   // access cycle counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
      end else if (start) begin
         busy <= 1'b1;
         cnt <= 4'h0;
      end else if (done) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt + 4'h1;
      end
   end

   // strobes held for the whole access
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sram_req <= '0;
      end else if (start) begin
         sram_req <= '{addr: addr, wdata: wdata, we: wr, re: !wr};
      end else if (done) begin
         sram_req.we <= 1'b0;
         sram_req.re <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: shared/irq_defines.svh */
// Function
// - reset and each source own distinct low vectors; lower vector wins
// - reset ranks first, ext_request_zero directly below it
// - a source is taken only with its enable and global enable both one
// - accepting an interrupt clears global enable
// - software setting global enable inside a handler lets handlers nest
// - return from handler sets global enable
// - hardware clears a source flag when it vectors to that handler
// - writing one to a flag bit clears it
// - events set their flag even while disabled; flag held until serviced or cleared
// - flags raised while globally disabled wait, then serve in priority order
// - level sources request only while their condition is present
// - after return, one interrupted instruction runs before the next interrupt
// - only the program counter is stacked; status word is never saved
// - disable instruction acts at once, blocking a same-cycle request too
// - instruction after the unmask instruction runs before any interrupt
// - entry takes four cycles pushing the program counter
// - jump at the vector takes three cycles to reach the handler
// - a multi-cycle instruction completes before interrupt service
// - waking from sleep adds four cycles to entry
// - return takes four cycles, pops two bytes, stack pointer plus two
// - program counter is 10, 11 or 12 bits, addressing 16-bit words
// - each stack sram access takes two clock cycles
// - core clock is used undivided
// - entry push decrements stack pointer by two, stack grows downward
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// register byte offsets
`define OFS_ENABLE 8'h00
`define OFS_FLAG 8'h04
`define OFS_STATUS 8'h08
`define OFS_STACK 8'h0c
`define OFS_STATE 8'h10

// status word layout and reset values
`define GIE_BIT 7
`define STATUS_RESET 8'h00
`define SP_RESET 16'h0000

// vector table layout, in program words
`define VEC_BASE 0
`define VEC_SLOT 1

// timing, in core clock cycles; stack pointer step in bytes
`define SRAM_ACCESS_CYCLES 2
`define ENTRY_CYCLES 4
`define WAKE_EXTRA_CYCLES 4
`define RETURN_CYCLES 4
`define JUMP_CYCLES 3
`define SP_STEP 2

`endif

/* File: shared/irq_pkg.sv */
package irq_pkg;
   // instruction class reported at each instruction boundary
   typedef enum logic [2:0] {
      OP_OTHER = 3'b000,
      OP_DISABLE = 3'b001,
      OP_UNMASK = 3'b010,
      OP_RETURN = 3'b011
   } op_t;

   typedef struct packed {
      op_t op;
      logic [15:0] next_pc;
   } core_retire_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } sram_req_t;

   typedef enum logic [2:0] {
      ST_RESET_VEC = 3'b000,
      ST_RUN = 3'b001,
      ST_WAKE = 3'b010,
      ST_PUSH_LO = 3'b011,
      ST_PUSH_HI = 3'b100,
      ST_POP_HI = 3'b101,
      ST_POP_LO = 3'b110
   } seq_state_t;
endpackage

/* File: tb/irq_entry_return_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.svh"
module irq_entry_return_sequencer_tb_top;
   import irq_pkg::*;
   localparam int NUM_SRC = 8;
   localparam int PC_W = 12;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [7:0] src_event = '0;
   logic [7:0] src_level = '0;
   logic retire_valid = 1'b0;
   core_retire_t retire = '0;
   logic sleeping = 1'b0;
   logic hready, hreadyout, hresp, core_hold, pc_load, handler_entered, global_enable;
   logic [31:0] hrdata, rd;
   logic [PC_W-1:0] pc_value;
   logic [7:0] sram_rdata;
   sram_req_t sram_req;
   int errors = 0;
   int total_checks = 0;
   int n;
   assign hready = hreadyout;
   irq_entry_return_sequencer #(.NUM_SRC(NUM_SRC), .PC_W(PC_W), .LEVEL_SRC(8'h80)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .src_event(src_event), .src_level(src_level), .retire_valid(retire_valid),
      .retire(retire), .sleeping(sleeping), .sram_req(sram_req), .sram_rdata(sram_rdata),
      .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value),
      .handler_entered(handler_entered), .global_enable(global_enable));
   stack_sram_model sram (.hclk(hclk), .sram_req(sram_req), .sram_rdata(sram_rdata));
   initial begin
      forever #50 hclk = ~hclk;
   end
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one single transfer; the leading edge keeps back-to-back calls from re-driving in one step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      // no local limit: only the watchdog may end a wait
      do begin @(posedge hclk); end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
      chk(hresp, 1'b0);
   endtask
   task automatic step(input op_t op, input logic [15:0] pc);
      @(posedge hclk);
      retire_valid <= 1'b1;
      retire <= '{op: op, next_pc: pc};
      @(posedge hclk);
      retire_valid <= 1'b0;
   endtask
   task automatic ev(input logic [7:0] m);
      @(posedge hclk);
      src_event <= m;
      @(posedge hclk);
      src_event <= '0;
   endtask
   // edges from the taking edge to the load; -1 when none comes
   task automatic wait_load(input int limit, output int cnt);
      cnt = -1;
      for (int i = 1; i <= limit && cnt < 0; i++) begin
         @(posedge hclk);
         #1;
         if (pc_load === 1'b1) cnt = i;
      end
      // realign to an edge so the caller's next drive lands on it
      @(posedge hclk);
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(`OFS_ENABLE, 32'h0);
      rchk(`OFS_STATUS, 32'h0);
      rchk(8'h20, 32'h0);
      bus(1'b1, `OFS_STACK, 32'h0100);
      bus(1'b1, `OFS_STATUS, 32'h05);
      bus(1'b1, `OFS_ENABLE, 32'hbf);
      ev(8'h0a);
      rchk(`OFS_FLAG, 32'h0a);
      bus(1'b1, `OFS_FLAG, 32'h08);
      rchk(`OFS_FLAG, 32'h02);
      bus(1'b1, `OFS_FLAG, 32'h00);
      rchk(`OFS_FLAG, 32'h02);
      ev(8'h08);
      step(OP_UNMASK, 16'h0111);
      wait_load(4, n);
      chk(n, -1);
      step(OP_OTHER, 16'h0122);
      wait_load(4, n);
      chk(n, -1);
      step(OP_OTHER, 16'h0234);
      wait_load(12, n);
      chk(n, `ENTRY_CYCLES);
      chk(pc_value, `VEC_BASE + 2 * `VEC_SLOT);
      chk(global_enable, 1'b0);
      rchk(`OFS_FLAG, 32'h08);
      rchk(`OFS_STACK, 32'h0100 - `SP_STEP);
      rchk(`OFS_STATUS, 32'h05);
      chk(sram.mem[9'h100], 8'h34);
      chk(sram.mem[9'h0ff], 8'h02);
      // nesting: a higher source preempts the running handler
      ev(8'h01);
      step(OP_UNMASK, 16'h0300);
      step(OP_OTHER, 16'h0301);
      step(OP_OTHER, 16'h0302);
      wait_load(12, n);
      chk(n, `ENTRY_CYCLES);
      chk(pc_value, `VEC_BASE + `VEC_SLOT);
      step(OP_RETURN, 16'h0);
      wait_load(12, n);
      chk(n, `RETURN_CYCLES);
      chk(pc_value, 12'h302);
      chk(global_enable, 1'b1);
      rchk(`OFS_STACK, 32'h00fe);
      rchk(`OFS_STATE, {23'h0, 1'b1, 5'h00, ST_RUN});
      step(OP_OTHER, 16'h0303);
      wait_load(6, n);
      chk(n, -1);
      step(OP_OTHER, 16'h0400);
      wait_load(12, n);
      chk(pc_value, `VEC_BASE + 4 * `VEC_SLOT);
      // disable retire against an already pending request
      ev(8'h20);
      bus(1'b1, `OFS_STATUS, 32'h80);
      step(OP_DISABLE, 16'h0410);
      wait_load(6, n);
      chk(n, -1);
      step(OP_OTHER, 16'h0411);
      wait_load(6, n);
      chk(n, -1);
      bus(1'b1, `OFS_FLAG, 32'h20);
      ev(8'h40);
      bus(1'b1, `OFS_STATUS, 32'h80);
      step(OP_OTHER, 16'h0420);
      wait_load(6, n);
      chk(n, -1);
      rchk(`OFS_FLAG, 32'h40);
      bus(1'b1, `OFS_ENABLE, 32'hff);
      step(OP_OTHER, 16'h0500);
      wait_load(12, n);
      chk(pc_value, `VEC_BASE + 7 * `VEC_SLOT);
      // level source: gone before enabling means no service
      src_level <= 8'h80;
      rchk(`OFS_FLAG, 32'h80);
      src_level <= 8'h00;
      bus(1'b1, `OFS_STATUS, 32'h80);
      step(OP_OTHER, 16'h0510);
      wait_load(6, n);
      chk(n, -1);
      src_level <= 8'h80;
      step(OP_OTHER, 16'h0520);
      wait_load(12, n);
      chk(pc_value, `VEC_BASE + 8 * `VEC_SLOT);
      src_level <= 8'h00;
      ev(8'h04);
      bus(1'b1, `OFS_STATUS, 32'h80);
      // core busy in a long instruction: no retire, so no take
      wait_load(3, n);
      chk(n, -1);
      @(posedge hclk);
      sleeping <= 1'b1;
      @(posedge hclk);
      wait_load(16, n);
      chk(n, `ENTRY_CYCLES + `WAKE_EXTRA_CYCLES);
      chk(pc_value, `VEC_BASE + 3 * `VEC_SLOT);
      sleeping <= 1'b0;
      summarize();
   end
   // run needs well under 2000 cycles
   initial begin
      #2000000;
      errors++;
      summarize();
   end
endmodule
bind irq_entry_return_sequencer irq_seq_monitor #(.NUM_SRC(NUM_SRC), .PC_W(PC_W)) mon (
   .hclk(hclk), .hresetn(hresetn), .retire_valid(retire_valid), .retire(retire), .sram_req(sram_req),
   .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value), .handler_entered(handler_entered),
   .global_enable(global_enable));
`default_nettype wire

/* File: tb/irq_seq_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module irq_seq_monitor
   import irq_pkg::*;
#(
   parameter int NUM_SRC = 8,
   parameter int PC_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic retire_valid,
   input wire irq_pkg::core_retire_t retire,
   input wire irq_pkg::sram_req_t sram_req,
   input wire logic core_hold,
   input wire logic pc_load,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic handler_entered,
   input wire logic global_enable
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // one stack byte spans two strobe cycles
   sequence push_byte_s;
      sram_req.we [*2];
   endsequence
   sequence pop_frame_s;
      sram_req.re [*4];
   endsequence
   // retire while running, not in a sequence
   sequence run_retire_s(op_t o);
      retire_valid && retire.op == o && !core_hold;
   endsequence
   entry_push_seq_a: assert property ($rose(sram_req.we) |-> push_byte_s ##1 push_byte_s ##1 (pc_load && !core_hold))
      else $error("entry push timing wrong");
   push_addr_step_a: assert property ($rose(sram_req.we) |-> ##2 sram_req.addr == $past(sram_req.addr, 2) - 16'h0001)
      else $error("push address did not step down");
   entry_vector_a: assert property (pc_load && $past(sram_req.we) |-> pc_value >= 1 && pc_value <= NUM_SRC)
      else $error("vector outside table");
   entry_gie_clear_a: assert property ($rose(sram_req.we) |-> !global_enable)
      else $error("global enable kept on entry");
   return_seq_a: assert property (run_retire_s(OP_RETURN) |=> pop_frame_s ##1 (pc_load && global_enable && !core_hold))
      else $error("return sequence wrong");
   unmask_guard_a: assert property (run_retire_s(OP_UNMASK) |=> global_enable && !core_hold)
      else $error("unmask retire was interrupted");
   disable_now_a: assert property (run_retire_s(OP_DISABLE) |=> !global_enable && !core_hold)
      else $error("disable retire was interrupted");
   handler_jump_a: assert property (pc_load && $past(sram_req.we) |-> ##3 handler_entered)
      else $error("handler reached late");
endmodule
`default_nettype wire

/* File: tb/stack_sram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module stack_sram_model (
   input wire logic hclk,
   input wire irq_pkg::sram_req_t sram_req,
   output logic [7:0] sram_rdata
);
   import irq_pkg::*;
   logic [7:0] mem [0:511];
   logic [7:0] last;
   // small array, stack kept below 0x200 by the bench
   always_ff @(posedge hclk) begin
      if (sram_req.we) begin
         mem[sram_req.addr[8:0]] <= sram_req.wdata;
      end
      if (sram_req.re) begin
         last <= mem[sram_req.addr[8:0]];
      end
   end
   // idle bus shows flipped data so a stale byte never passes
   assign sram_rdata = sram_req.re ? mem[sram_req.addr[8:0]] : ~last;
endmodule
`default_nettype wire
